// file: burst_length_adapter.sv
// ==========================================================================
// burst length adapter between a bursting master port and a slave port
// assumes the master holds a request until it sees wait low, and the slave
// returns read data in order; both sides share one clock and data width
// ==========================================================================
//
`timescale 1ns/10ps
module burst_length_adapter #(
   parameter logic [burst_pkg::CNT_W-1:0] MASTER_MAX =
      burst_pkg::MASTER_MAX_DEFAULT,
   parameter logic [burst_pkg::CNT_W-1:0] SLAVE_MAX  =
      burst_pkg::SLAVE_MAX_DEFAULT,
   parameter bit SLAVE_BURSTS             = 1'b1,
   parameter bit WRAPS_AT_BURST_BOUNDARY  = 1'b0,
   parameter bit MASTER_WRAPS             = 1'b0,
   parameter bit ALWAYS_FULL_LENGTH_BURST = 1'b0
) (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic [burst_pkg::ADDR_W-1:0] m_address,
   input  wire logic                         m_read,
   input  wire logic                         m_write,
   input  wire logic [burst_pkg::DATA_W-1:0] m_writedata,
   input  wire logic [burst_pkg::CNT_W-1:0]  m_burstcount,
   output logic                              m_waitrequest,
   output logic      [burst_pkg::DATA_W-1:0] m_readdata,
   output logic                              m_readdatavalid,
   output logic      [burst_pkg::ADDR_W-1:0] s_address,
   output logic                              s_read,
   output logic                              s_write,
   output logic      [burst_pkg::DATA_W-1:0] s_writedata,
   output logic      [burst_pkg::CNT_W-1:0]  s_burstcount,
   input  wire logic                         s_waitrequest,
   input  wire logic [burst_pkg::DATA_W-1:0] s_readdata,
   input  wire logic                         s_readdatavalid,
   output logic                              s_lock
);
   import burst_pkg::*;

   // ======================================================================
   // state
   state_type        state_reg,      state_next;
   logic [WIDX_W-1:0] addr_reg,      addr_next;
   logic [CNT_W-1:0] remain_reg,     remain_next;
   logic [CNT_W-1:0] sub_left_reg,   sub_left_next;
   logic             is_write_reg,   is_write_next;
   logic [ADDR_W-1:0] s_address_reg, s_address_next;
   logic             s_read_reg,     s_read_next;
   logic             s_write_reg,    s_write_next;
   logic [DATA_W-1:0] s_wdata_reg,   s_wdata_next;
   logic [CNT_W-1:0] s_count_reg,    s_count_next;
   logic             m_wait_reg,     m_wait_next;
   logic             lock_reg,       lock_next;
   logic [DATA_W-1:0] m_rdata_reg;
   logic             m_rvalid_reg;

   logic [CNT_W-1:0]  sub_len;
   logic [CNT_W-1:0]  req_count;
   logic [WIDX_W-1:0] len_wide;
   logic [WIDX_W-1:0] wrap_mask;
   logic [WIDX_W-1:0] addr_sum;
   logic              cmd_taken;
   logic              beat_load;
   logic              beat_done;
   logic              all_done;

   // ======================================================================
   // sub-burst length; each port's maximum stays its own parameter
   burst_length_calc calc (
      .word_index   (addr_reg),
      .remaining    (remain_reg),
      .slave_max    (SLAVE_MAX),
      .slave_bursts (SLAVE_BURSTS),
      .slave_wraps  (WRAPS_AT_BURST_BOUNDARY),
      .master_wraps (MASTER_WRAPS),
      .sub_len      (sub_len)
   );

   // words of the master burst still to finish; lock follows it
   beat_counter beats (
      .clk        (clk),
      .rst        (rst),
      .load       (beat_load),
      .load_value (req_count),
      .dec        (beat_done),
      .zero       (all_done)
   );

   // a wrapping master always bursts full length, so its count is known
   assign req_count = ALWAYS_FULL_LENGTH_BURST ? MASTER_MAX : m_burstcount;
   assign len_wide  = WIDX_W'(sub_len);
   assign wrap_mask = WIDX_W'(MASTER_MAX) - WIDX_W'(ONE_WORD);
   assign addr_sum  = addr_reg + len_wide;
   assign cmd_taken = (s_read_reg || s_write_reg) && !s_waitrequest;
   assign beat_load = (state_reg == ST_IDLE) && (m_read || m_write);
   // a read word is done when its data is back, a write word when taken
   assign beat_done = is_write_reg ? (s_write_reg && !s_waitrequest)
                                   : (s_readdatavalid && lock_reg);

   // ======================================================================
   // sequencer next state
   always_comb begin
      state_next     = state_reg;
      addr_next      = addr_reg;
      remain_next    = remain_reg;
      sub_left_next  = sub_left_reg;
      is_write_next  = is_write_reg;
      s_address_next = s_address_reg;
      s_read_next    = s_read_reg;
      s_write_next   = s_write_reg;
      s_wdata_next   = s_wdata_reg;
      s_count_next   = s_count_reg;
      m_wait_next    = 1'b1;
      lock_next      = lock_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (m_read || m_write) begin
               addr_next     = m_address[ADDR_W-1:BYTE_SHIFT];
               remain_next   = req_count;
               is_write_next = m_write;
               lock_next     = 1'b1;
               state_next    = ST_GAP;
            end
         end
         ST_GAP: begin
            // slave strobes stay low here: the one idle cycle
            if (!is_write_reg || m_write) begin
               s_address_next = {addr_reg, BYTE_OFFSET};
               s_count_next   = sub_len;
               s_read_next    = !is_write_reg;
               s_write_next   = is_write_reg;
               s_wdata_next   = m_writedata;
               sub_left_next  = sub_len;
               remain_next    = remain_reg - sub_len;
               if (MASTER_WRAPS) begin
                  addr_next = (addr_reg & ~wrap_mask) | (addr_sum & wrap_mask);
               end else begin
                  addr_next = addr_sum;
               end
               state_next     = ST_ISSUE;
            end
         end
         ST_ISSUE: begin
            if (cmd_taken) begin
               s_read_next  = 1'b0;
               s_write_next = 1'b0;
               if (is_write_reg) begin
                  // take this master word only now the slave holds it
                  m_wait_next   = 1'b0;
                  sub_left_next = sub_left_reg - ONE_WORD;
                  state_next    = ST_WACK;
               end else if (remain_reg == CNT_RESET) begin
                  m_wait_next = 1'b0;
                  state_next  = ST_DRAIN;
               end else begin
                  state_next = ST_GAP;
               end
            end
         end
         ST_WACK: begin
            // master sees wait low this cycle; its next word comes next
            if (sub_left_reg != CNT_RESET) begin
               state_next = ST_WLOAD;
            end else if (remain_reg != CNT_RESET) begin
               state_next = ST_GAP;
            end else begin
               state_next = ST_DRAIN;
            end
         end
         ST_WLOAD: begin
            // next word of the same slave burst, no idle cycle needed
            if (m_write) begin
               s_write_next = 1'b1;
               s_wdata_next = m_writedata;
               state_next   = ST_ISSUE;
            end
         end
         ST_DRAIN: begin
            // hold the slave until every read word has come back
            if (all_done) begin
               lock_next  = 1'b0;
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   // ======================================================================
   // sequencer registers
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg     <= ST_IDLE;
         addr_reg      <= WIDX_RESET;
         remain_reg    <= CNT_RESET;
         sub_left_reg  <= CNT_RESET;
         is_write_reg  <= 1'b0;
         s_address_reg <= ADDR_RESET;
         s_read_reg    <= 1'b0;
         s_write_reg   <= 1'b0;
         s_wdata_reg   <= DATA_RESET;
         s_count_reg   <= CNT_RESET;
         m_wait_reg    <= 1'b1;
         lock_reg      <= 1'b0;
      end else begin
         state_reg     <= state_next;
         addr_reg      <= addr_next;
         remain_reg    <= remain_next;
         sub_left_reg  <= sub_left_next;
         is_write_reg  <= is_write_next;
         s_address_reg <= s_address_next;
         s_read_reg    <= s_read_next;
         s_write_reg   <= s_write_next;
         s_wdata_reg   <= s_wdata_next;
         s_count_reg   <= s_count_next;
         m_wait_reg    <= m_wait_next;
         lock_reg      <= lock_next;
      end
   end

   // ======================================================================
   // read return: one register stage keeps slave order intact
   always_ff @(posedge clk) begin
      if (rst) begin
         m_rdata_reg  <= DATA_RESET;
         m_rvalid_reg <= 1'b0;
      end else begin
         m_rdata_reg  <= s_readdata;
         m_rvalid_reg <= s_readdatavalid && lock_reg && !is_write_reg;
      end
   end

   // outputs straight from flip-flops
   assign m_waitrequest   = m_wait_reg;
   assign m_readdata      = m_rdata_reg;
   assign m_readdatavalid = m_rvalid_reg;
   assign s_address       = s_address_reg;
   assign s_read          = s_read_reg;
   assign s_write         = s_write_reg;
   assign s_writedata     = s_wdata_reg;
   assign s_burstcount    = s_count_reg;
   assign s_lock          = lock_reg;

   // ======================================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_read_taken_more;
      s_read_reg && !s_waitrequest && remain_reg != CNT_RESET;
   endsequence

   sequence s_gap_then_issue;
      !s_read_reg ##1 s_read_reg;
   endsequence

   property p_onehot_state;
      $onehot(state_reg);
   endproperty
   a_onehot_state: assert property (p_onehot_state)
      else $error("sequencer state is not one-hot");

   property p_len_limit;
      (s_read_reg || s_write_reg)
         |-> s_count_reg != CNT_RESET && s_count_reg <= SLAVE_MAX;
   endproperty
   a_len_limit: assert property (p_len_limit)
      else $error("slave burst length outside one to slave maximum");

   property p_single_word;
      (!SLAVE_BURSTS && (s_read_reg || s_write_reg))
         |-> s_count_reg == ONE_WORD;
   endproperty
   a_single_word: assert property (p_single_word)
      else $error("non-bursting slave got a multi-word burst");

   property p_locked_while_busy;
      (s_read_reg || s_write_reg || state_reg == ST_DRAIN) |-> lock_reg;
   endproperty
   a_locked_while_busy: assert property (p_locked_while_busy)
      else $error("slave unlocked while the master burst is open");

   property p_idle_before_read;
      $rose(s_read_reg) |-> $past(state_reg) == ST_GAP && $past(!s_write_reg);
   endproperty
   a_idle_before_read: assert property (p_idle_before_read)
      else $error("read burst issued without a preceding idle cycle");

   property p_stay_in_region;
      (WRAPS_AT_BURST_BOUNDARY && !MASTER_WRAPS && $rose(s_read_reg))
         |-> (s_address_reg[BYTE_SHIFT+CNT_W-1:BYTE_SHIFT]
              & (SLAVE_MAX - ONE_WORD)) + s_count_reg <= SLAVE_MAX;
   endproperty
   a_stay_in_region: assert property (p_stay_in_region)
      else $error("slave burst crosses a wrap boundary");

   property p_next_after_accept;
      s_read_taken_more |=> s_gap_then_issue;
   endproperty
   a_next_after_accept: assert property (p_next_after_accept)
      else $error("next sub-burst not issued after one idle cycle");

   property p_release_last;
      (!m_wait_reg && !is_write_reg)
         |-> $past(s_read_reg && !s_waitrequest && remain_reg == CNT_RESET);
   endproperty
   a_release_last: assert property (p_release_last)
      else $error("master released before its last sub-burst was taken");

   property p_unlock_when_done;
      (state_reg == ST_DRAIN && all_done)
         |=> (!lock_reg && state_reg == ST_IDLE)
             ##1 (!lock_reg || state_reg == ST_GAP);
   endproperty
   a_unlock_when_done: assert property (p_unlock_when_done)
      else $error("lock not dropped when the master burst finished");

   property p_read_in_order;
      (s_readdatavalid && lock_reg && !is_write_reg)
         |=> m_rvalid_reg && m_rdata_reg == $past(s_readdata);
   endproperty
   a_read_in_order: assert property (p_read_in_order)
      else $error("read data not returned in slave order");

endmodule

// file: burst_pkg.sv
// ==========================================================================
// burst adapter constants: widths, per-port burst limits, fsm states
// assumes one 100 MHz clock and a synchronous active-high reset everywhere
// ==========================================================================
package burst_pkg;

   // ======================================================================
   // widths
   localparam int ADDR_W     = 32;
   localparam int DATA_W     = 32;
   localparam int CNT_W      = 5;
   localparam int BYTE_SHIFT = 2;
   localparam int WIDX_W     = ADDR_W - BYTE_SHIFT;

   // ======================================================================
   // burst limits and reset values
   localparam logic [CNT_W-1:0]  MASTER_MAX_DEFAULT = 5'h10;
   localparam logic [CNT_W-1:0]  SLAVE_MAX_DEFAULT  = 5'h08;
   localparam logic [CNT_W-1:0]  ONE_WORD           = 5'h01;
   localparam logic [CNT_W-1:0]  CNT_RESET          = 5'h00;
   localparam logic [WIDX_W-1:0] WIDX_RESET         = 30'h0;
   localparam logic [ADDR_W-1:0] ADDR_RESET         = 32'h0;
   localparam logic [DATA_W-1:0] DATA_RESET         = 32'h0;
   localparam logic [BYTE_SHIFT-1:0] BYTE_OFFSET    = 2'h0;

   // ======================================================================
   // sequencer states
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_GAP   = 6'b000010,
      ST_ISSUE = 6'b000100,
      ST_WACK  = 6'b001000,
      ST_WLOAD = 6'b010000,
      ST_DRAIN = 6'b100000
   } state_type;

endpackage

// file: burst_length_calc.sv
// ==========================================================================
// length of the next slave sub-burst from position, remainder and limits
// assumes power-of-two slave maximum; purely combinational
// ==========================================================================
`timescale 1ns/10ps
module burst_length_calc (
   input  wire logic [burst_pkg::WIDX_W-1:0] word_index,
   input  wire logic [burst_pkg::CNT_W-1:0]  remaining,
   input  wire logic [burst_pkg::CNT_W-1:0]  slave_max,
   input  wire logic                         slave_bursts,
   input  wire logic                         slave_wraps,
   input  wire logic                         master_wraps,
   output logic      [burst_pkg::CNT_W-1:0]  sub_len
);
   import burst_pkg::*;

   logic [CNT_W-1:0] limit;
   logic [CNT_W-1:0] room;

   // ======================================================================
   // limit by slave maximum, then by words left in the wrap region
   always_comb begin
      room  = slave_max - (word_index[CNT_W-1:0] & (slave_max - ONE_WORD));
      limit = slave_bursts ? slave_max : ONE_WORD;
      // word 3 with limit 8 leaves room 5, then word 8 starts anew
      if (slave_bursts && slave_wraps && !master_wraps && room < limit) begin
         limit = room;
      end
      sub_len = (remaining < limit) ? remaining : limit;
   end

endmodule

// file: beat_counter.sv
// ==========================================================================
// down counter of master words still to complete for the locked burst
// assumes load and decrement never arrive together
// ==========================================================================
`timescale 1ns/10ps
module beat_counter (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        load,
   input  wire logic [burst_pkg::CNT_W-1:0] load_value,
   input  wire logic                        dec,
   output logic                             zero
);
   import burst_pkg::*;

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;

   // ======================================================================
   // next count; saturates at zero so a stray beat cannot wrap it
   always_comb begin
      count_next = count_reg;
      if (load) begin
         count_next = load_value;
      end else if (dec && count_reg != CNT_RESET) begin
         count_next = count_reg - ONE_WORD;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_reg <= CNT_RESET;
      end else begin
         count_reg <= count_next;
      end
   end

   assign zero = (count_reg == CNT_RESET);

   // ======================================================================
   // checks
   property p_count_down;
      @(posedge clk) disable iff (rst)
      (!load && dec && count_reg != CNT_RESET)
         |=> count_reg == $past(count_reg) - ONE_WORD;
   endproperty
   a_count_down: assert property (p_count_down)
      else $error("beat counter did not step down on a beat");

endmodule

// file: mem_slave_model.sv
// ==========================================================================
// behavioural slave for the burst adapter: word memory, random stalls and
// in-order read return with random gaps; shares the adapter's clock
// ==========================================================================
`timescale 1ns/10ps
module mem_slave_model (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic [burst_pkg::ADDR_W-1:0] s_address,
   input  wire logic                         s_read,
   input  wire logic                         s_write,
   input  wire logic [burst_pkg::DATA_W-1:0] s_writedata,
   input  wire logic [burst_pkg::CNT_W-1:0]  s_burstcount,
   output logic                              s_waitrequest,
   output logic      [burst_pkg::DATA_W-1:0] s_readdata,
   output logic                              s_readdatavalid
);
   import burst_pkg::*;
   logic [DATA_W-1:0] mem [int];
   int                rd_q[$];
   int                seed  = 87;
   int                wleft = 0;
   int                waddr = 0;

   // unwritten words read back as a pattern of their own word index
   function automatic logic [DATA_W-1:0] word_at(int a);
      if (mem.exists(a)) return mem[a];
      return {a[15:0], ~a[15:0]};
   endfunction

   initial begin
      s_waitrequest   = 1'b1;
      s_readdata      = DATA_RESET;
      s_readdatavalid = 1'b0;
   end

   // ======================================================================
   // accept commands, store writes, return reads in order
   always @(posedge clk) begin
      s_waitrequest <= rst ? 1'b1 : ($random(seed) % 3 == 0);
      if (!rst && s_read && !s_waitrequest) begin
         for (int i = 0; i < int'(s_burstcount); i++)
            rd_q.push_back(int'(s_address) / 4 + i);
      end
      if (!rst && s_write && !s_waitrequest) begin
         if (wleft == 0) begin
            waddr = int'(s_address) / 4;
            wleft = int'(s_burstcount);
         end
         mem[waddr] = s_writedata;
         waddr++;
         wleft--;
      end
      // idle data bus toggles so a stale word never looks valid
      if (rd_q.size() > 0 && $random(seed) % 2 == 0) begin
         s_readdatavalid <= 1'b1;
         s_readdata      <= word_at(rd_q.pop_front());
      end else begin
         s_readdatavalid <= 1'b0;
         s_readdata      <= ~s_readdata;
      end
   end
endmodule

// file: burst_lane.sv
// ==========================================================================
// one adapter configuration with its slave, master driver and scoreboard
// assumes clk and rst come from the top; reports counts and done upward
// ==========================================================================
`timescale 1ns/10ps
module burst_lane #(
   parameter bit SB = 1'b1,
   parameter bit WR = 1'b1
) (
   input  wire logic clk,
   input  wire logic rst,
   output logic      done,
   output int        errs,
   output int        cmps
);
   import burst_pkg::*;
   localparam int SM = 8;
   logic [ADDR_W-1:0] m_address, s_address;
   logic [DATA_W-1:0] m_writedata, m_readdata, s_writedata, s_readdata;
   logic [CNT_W-1:0]  m_burstcount, s_burstcount;
   logic              m_read, m_write, m_waitrequest, m_readdatavalid;
   logic              s_read, s_write, s_waitrequest, s_readdatavalid, s_lock;
   logic [DATA_W-1:0] exp_mem [int];
   int                ca_q[$], cc_q[$], rd_q[$];
   int                seed = 87;
   int                wleft = 0;
   int                wa = 0;
   bit                acc_prev = 1'b0;
   bit                started = 1'b0;

   // master does not wrap, so full-length bursts are not demanded
   // port limits stay at their defaults of sixteen and eight, as SM assumes
   burst_length_adapter #(
      .SLAVE_BURSTS(SB), .WRAPS_AT_BURST_BOUNDARY(WR)) dut (
      .clk(clk), .rst(rst), .m_address(m_address), .m_read(m_read),
      .m_write(m_write), .m_writedata(m_writedata),
      .m_burstcount(m_burstcount), .m_waitrequest(m_waitrequest),
      .m_readdata(m_readdata), .m_readdatavalid(m_readdatavalid),
      .s_address(s_address), .s_read(s_read), .s_write(s_write),
      .s_writedata(s_writedata), .s_burstcount(s_burstcount),
      .s_waitrequest(s_waitrequest), .s_readdata(s_readdata),
      .s_readdatavalid(s_readdatavalid), .s_lock(s_lock));
   mem_slave_model slave (
      .clk(clk), .rst(rst), .s_address(s_address), .s_read(s_read),
      .s_write(s_write), .s_writedata(s_writedata),
      .s_burstcount(s_burstcount), .s_waitrequest(s_waitrequest),
      .s_readdata(s_readdata), .s_readdatavalid(s_readdatavalid));

   // ======================================================================
   // scoreboard helpers
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      cmps++;
      if (got !== exp) begin
         errs++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [DATA_W-1:0] word_exp(int a);
      if (exp_mem.exists(a)) return exp_mem[a];
      return {a[15:0], ~a[15:0]};
   endfunction

   // expected slave bursts: limit, remainder, then room to the boundary
   task automatic plan(int a, int len);
      int w;
      int l;
      w = a / 4;
      while (len > 0) begin
         l = SB ? SM : 1;
         if (l > len) l = len;
         if (WR && SB && l > SM - w % SM) l = SM - w % SM;
         ca_q.push_back(w * 4);
         cc_q.push_back(l);
         w += l;
         len -= l;
      end
   endtask

   task automatic wait_ack();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (m_waitrequest !== 1'b0 && n < 400);
      if (n >= 400) check("master ack", 0, 1);
   endtask

   // lock must fall once nothing of the burst is left outstanding
   task automatic finish_burst();
      int n;
      n = 0;
      while (ca_q.size() + rd_q.size() != 0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      check("pending items", 0, ca_q.size() + rd_q.size());
      ca_q.delete();
      cc_q.delete();
      rd_q.delete();
      repeat (4) @(posedge clk);
      check("lock released", 0, 32'(s_lock));
   endtask

   task automatic rd(int a, int len);
      plan(a, len);
      for (int w = 0; w < len; w++) rd_q.push_back(a / 4 + w);
      started = 1'b0;
      m_address    <= a;
      m_burstcount <= len[CNT_W-1:0];
      m_read       <= 1'b1;
      wait_ack();
      m_read <= 1'b0;
      finish_burst();
   endtask

   task automatic wr(int a, int len);
      logic [DATA_W-1:0] d;
      plan(a, len);
      started = 1'b0;
      for (int i = 0; i < len; i++) begin
         d = $random(seed);
         exp_mem[a / 4 + i] = d;
         m_address    <= a;
         m_burstcount <= len[CNT_W-1:0];
         m_writedata  <= d;
         m_write      <= 1'b1;
         wait_ack();
      end
      m_write <= 1'b0;
      finish_burst();
   endtask

   // ======================================================================
   // monitor of both sides, compared against the queues above
   always @(posedge clk) begin
      if (!rst) begin
         if (m_read && m_waitrequest === 1'b0)
            check("commands left at release", 0, ca_q.size());
         if ((s_read || s_write) && (s_read || wleft == 0) && acc_prev)
            check("idle before burst", 0, 1);
         if (m_readdatavalid === 1'b1)
            check("read word", word_exp(rd_q.pop_front()), m_readdata);
         if (started && ca_q.size() + rd_q.size() != 0)
            check("lock held", 1, 32'(s_lock));
         if ((s_read || s_write) && s_waitrequest === 1'b0) begin
            started = 1'b1;
            check("lock with command", 1, 32'(s_lock));
            if (s_read || wleft == 0) begin
               check("sub address", ca_q.pop_front(), s_address);
               check("sub count", cc_q.pop_front(), 32'(s_burstcount));
               wleft = s_write ? int'(s_burstcount) : 0;
               wa = int'(s_address) / 4;
            end
            if (s_write) begin
               check("write word", word_exp(wa), s_writedata);
               wa++;
               wleft--;
            end
         end
      end
      acc_prev = (s_read || s_write) && s_waitrequest === 1'b0;
   end

   // ======================================================================
   // stimulus sequence
   initial begin
      int a;
      int l;
      m_address = ADDR_RESET;
      m_read = 1'b0;
      m_write = 1'b0;
      m_writedata = DATA_RESET;
      m_burstcount = CNT_RESET;
      errs = 0;
      cmps = 0;
      done = 1'b0;
      wait (rst === 1'b0);
      @(posedge clk);
      check("wait after reset", 1, 32'(m_waitrequest));
      wr(32'h40, 14); // eight plus six, or fourteen singles
      rd(32'h40, 14);
      rd(32'h0, 16); // two full bursts or sixteen singles
      rd(32'hc, 8); // five then three at a wrapping slave
      wr(32'hc, 8);
      a = ($random(seed) & 32'h3f) * 4;
      l = ($random(seed) & 32'hf) + 1;
      wr(a, l);
      rd(a, l);
      rd(32'h4, 1);
      done = 1'b1;
   end
endmodule

// file: burst_length_adapter_tb_top.sv
// ==========================================================================
// top of the adapter bench: clock, reset, two slave configurations
// assumes each lane raises done after its own sequence
// ==========================================================================
`timescale 1ns/10ps
module burst_length_adapter_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   int   error_cnt = 0;
   int   compares = 0;
   int   cycles = 0;
   int   e0, e1, c0, c1;
   logic d0, d1;

   always #5 clk = ~clk;

   // wrapping bursting slave, and a slave with no burst support
   burst_lane #(.SB(1'b1), .WR(1'b1)) wrap_lane (
      .clk(clk), .rst(rst), .done(d0), .errs(e0), .cmps(c0));
   burst_lane #(.SB(1'b0), .WR(1'b0)) single_lane (
      .clk(clk), .rst(rst), .done(d1), .errs(e1), .cmps(c1));

   task automatic end_sim();
      error_cnt += e0 + e1;
      compares += c0 + c1;
      if (error_cnt == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      wait (d0 === 1'b1 && d1 === 1'b1);
      end_sim();
   end

   // a hang counts as a mismatch; the sequence needs a few hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         end_sim();
      end
   end
endmodule
